// [design/dlc_top.sv]
// Digital loop compensator with gain reduction and phase offset
`timescale 1ns/100ps
// Functional notes
// - Error times proportional gain, bits 15:0 of loop word, sets pulse width.
// - Integral term weighted by loop word bits 31:24.
// - Residual term, bits 23:16, trims proportional deviation of pulse width.
// - Residual acts one switching cycle after the proportional term.
// - Error compared each cycle to 12-bit threshold in reduction word.
// - Error low for observation period: gain divided per 2-bit setting.
// - Error above threshold restores full gain in that same cycle.
// - Default proportional gain after reset comes from the strap pin.
// - Parameters written only by commands DFh, D5h and 37h, and the proportional gain once by the strap.
// - Cycle start delayed from sync by 22.5..360 degrees via command 37h.
module dlc_top
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic sync_clk_pin,
    input wire logic [1:0] config_strap_pin_a,
    // Sensed output-voltage error, same clock domain
    input wire logic signed [ERR_W-1:0] vout_error,
    // Management command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_ack_ff,
    output logic cmd_err_ff,
    output logic [31:0] cmd_rdata_ff,
    // Loop outputs
    output logic pwm_out,
    output logic [PW_W-1:0] pulse_width_ff,
    output logic [LVL_W-1:0] red_level_ff
);
    // Pin synchronisers and strap catch
    logic sync_m_ff, sync_s_ff;
    logic [1:0] strap_m_ff, strap_s_ff;
    logic strap_vld_m_ff, strap_vld_s_ff;
    logic strap_done_ff, nxt_strap_done;
    logic strap_load;
    logic [15:0] strap_gain;

    // Configuration registers and command answer
    logic [31:0] loop_gain_config_ff, nxt_loop_gain;
    logic [15:0] gain_reduction_config_ff, nxt_gain_red;
    logic [PH_W-1:0] phase_offset_select_ff, nxt_phase;
    logic nxt_ack, nxt_err;
    logic [31:0] nxt_rdata;

    // Gain reduction state
    logic [OBS_W-1:0] obs_cnt_ff, nxt_obs_cnt;
    logic [LVL_W-1:0] nxt_level;
    logic [ERR_W:0] abs_err;
    logic err_over;
    logic [15:0] gain_eff;

    // Loop state, terms and cycle timing
    logic signed [23:0] integ_ff, nxt_integ;
    logic signed [23:0] prev_p_ff, nxt_prev_p;
    logic [PW_W-1:0] nxt_pw;
    logic pwm_start_ff;
    logic cycle_start;
    logic [PW_W-1:0] period;
    logic signed [40:0] p_prod;
    logic signed [40:0] i_prod;
    logic signed [40:0] r_prod;
    logic signed [23:0] p_term;
    logic signed [23:0] r_term;
    logic signed [25:0] sum;
    logic signed [23:0] pw_max;

    // Two-stage synchronisers for pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_m_ff <= 1'b0;
            sync_s_ff <= 1'b0;
            strap_m_ff <= 2'h0;
            strap_s_ff <= 2'h0;
        end else begin
            sync_m_ff <= sync_clk_pin;
            sync_s_ff <= sync_m_ff;
            strap_m_ff <= config_strap_pin_a;
            strap_s_ff <= strap_m_ff;
        end
    end

    // Cycle timing from the common sync clock
    dlc_phase u_phase (
        .clk(clk),
        .rst(rst),
        .sync_lvl(sync_s_ff),
        .phase_code(phase_offset_select_ff),
        .cycle_start_ff(cycle_start),
        .period_ff(period)
    );

    // Strap-selected default gain
    always_comb begin
        case (strap_s_ff)
            2'h0: strap_gain = STRAP_GAIN_0;
            2'h1: strap_gain = STRAP_GAIN_1;
            2'h2: strap_gain = STRAP_GAIN_2;
            default: strap_gain = STRAP_GAIN_3;
        endcase
    end

    // Strap catch once both synchroniser stages hold the pin value
    always_comb begin
        nxt_strap_done = strap_done_ff;
        strap_load = 1'b0;
        if (!strap_done_ff && strap_vld_s_ff) begin
            strap_load = 1'b1;
            nxt_strap_done = 1'b1;
        end
        if (cmd_valid && cmd_write && (cmd_code == CMD_LOOP_GAIN)) begin
            nxt_strap_done = 1'b1;             // Host gain wins over the strap
        end
    end

    // Strap catch registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_vld_m_ff <= 1'b0;
            strap_vld_s_ff <= 1'b0;
            strap_done_ff <= 1'b0;
        end else begin
            strap_vld_m_ff <= 1'b1;
            strap_vld_s_ff <= strap_vld_m_ff;
            strap_done_ff <= nxt_strap_done;
        end
    end

    // Command decode, register writes and read-back
    always_comb begin
        nxt_loop_gain = loop_gain_config_ff;
        nxt_gain_red = gain_reduction_config_ff;
        nxt_phase = phase_offset_select_ff;
        nxt_ack = 1'b0;
        nxt_err = 1'b0;
        nxt_rdata = cmd_rdata_ff;
        // Strap value loaded once, a host write in the same cycle wins
        if (strap_load) begin
            nxt_loop_gain[GAIN_LSB +: 16] = strap_gain;
        end
        if (cmd_valid) begin
            nxt_ack = 1'b1;
            nxt_rdata = 32'h0000_0000;
            case (cmd_code)
                CMD_LOOP_GAIN: begin
                    if (cmd_write) begin
                        nxt_loop_gain = cmd_wdata;
                    end else begin
                        nxt_rdata = loop_gain_config_ff;
                    end
                end
                CMD_GAIN_RED: begin
                    if (cmd_write) begin
                        nxt_gain_red = cmd_wdata[15:0];
                    end else begin
                        nxt_rdata = {16'h0000, gain_reduction_config_ff};
                    end
                end
                CMD_PHASE: begin
                    if (cmd_write) begin
                        nxt_phase = cmd_wdata[PH_W-1:0];
                    end else begin
                        nxt_rdata = {28'h0000000, phase_offset_select_ff};
                    end
                end
                default: begin
                    nxt_err = 1'b1;            // Unknown code: no effect
                end
            endcase
        end
    end

    // Gain reduction tracking
    always_comb begin
        abs_err = vout_error[ERR_W-1] ? (ERR_W+1)'(-vout_error) : (ERR_W+1)'(vout_error);
        err_over = abs_err > (ERR_W+1)'(gain_reduction_config_ff[THR_LSB +: THR_W]);
        nxt_obs_cnt = obs_cnt_ff;
        nxt_level = red_level_ff;
        if (cycle_start) begin
            if (err_over) begin
                nxt_level = '0;
                nxt_obs_cnt = '0;
            end else if (obs_cnt_ff >= OBS_CYCLES - 5'h01) begin
                nxt_obs_cnt = '0;
                if (red_level_ff < gain_reduction_config_ff[RED_LSB +: LVL_W]) begin
                    nxt_level = red_level_ff + 2'h1;
                end
            end else begin
                nxt_obs_cnt = obs_cnt_ff + 5'h01;
            end
            if (nxt_level > gain_reduction_config_ff[RED_LSB +: LVL_W]) begin
                nxt_level = gain_reduction_config_ff[RED_LSB +: LVL_W];
            end
        end
        // Divisor two to the level, code zero leaves the gain whole
        gain_eff = loop_gain_config_ff[GAIN_LSB +: 16] >> nxt_level;
    end

    // Gain reduction registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            obs_cnt_ff <= '0;
            red_level_ff <= '0;
        end else begin
            obs_cnt_ff <= nxt_obs_cnt;
            red_level_ff <= nxt_level;
        end
    end

    // Proportional and integral terms of the present error, residual of the previous proportional term
    always_comb begin
        pw_max = 24'(period) - 24'sd1;
        p_prod = 41'(vout_error) * $signed({25'h0, gain_eff});
        p_term = 24'(p_prod >>> P_SHIFT);
        i_prod = 41'(vout_error)
               * $signed({33'h0, loop_gain_config_ff[INTEG_LSB +: 8]});
        r_prod = 41'(prev_p_ff)
               * $signed({33'h0, loop_gain_config_ff[RESID_LSB +: 8]});
        r_term = -24'(r_prod >>> R_SHIFT);
    end

    // Loop update, evaluated at each cycle start
    always_comb begin
        nxt_integ = integ_ff;
        nxt_prev_p = prev_p_ff;
        nxt_pw = pulse_width_ff;
        if (cycle_start) begin
            nxt_integ = integ_ff + 24'(i_prod >>> I_SHIFT);
            // Anti-windup on the integrator
            if (nxt_integ < 24'sd0) begin
                nxt_integ = 24'sd0;
            end else if (nxt_integ > pw_max) begin
                nxt_integ = pw_max;
            end
            nxt_prev_p = p_term;
            sum = 26'(nxt_integ) + 26'(p_term) + 26'(r_term);
            if (sum < 26'sd0) begin
                nxt_pw = '0;
            end else if (sum > 26'(pw_max)) begin
                nxt_pw = pw_max[PW_W-1:0];
            end else begin
                nxt_pw = sum[PW_W-1:0];
            end
        end else begin
            sum = 26'sd0;
        end
    end

    // Loop registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            integ_ff <= '0;
            prev_p_ff <= '0;
            pulse_width_ff <= '0;
        end else begin
            integ_ff <= nxt_integ;
            prev_p_ff <= nxt_prev_p;
            pulse_width_ff <= nxt_pw;
        end
    end

    // Pulse start one clock after the width update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_start_ff <= 1'b0;
        end else begin
            pwm_start_ff <= cycle_start;
        end
    end

    // Configuration and command registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_gain_config_ff <= LOOP_GAIN_RST;
            gain_reduction_config_ff <= GAIN_RED_RST;
            phase_offset_select_ff <= PHASE_RST;
            cmd_ack_ff <= 1'b0;
            cmd_err_ff <= 1'b0;
            cmd_rdata_ff <= 32'h0000_0000;
        end else begin
            loop_gain_config_ff <= nxt_loop_gain;
            gain_reduction_config_ff <= nxt_gain_red;
            phase_offset_select_ff <= nxt_phase;
            cmd_ack_ff <= nxt_ack;
            cmd_err_ff <= nxt_err;
            cmd_rdata_ff <= nxt_rdata;
        end
    end

    // Pulse output, started once the new width is registered
    dlc_pwm u_pwm (
        .clk(clk),
        .rst(rst),
        .start(pwm_start_ff),
        .width(pulse_width_ff),
        .pwm_ff(pwm_out)
    );
endmodule : dlc_top

// [design/dlc_pkg.sv]
// Constants, command codes and field layouts of the loop compensator
package dlc_pkg;
    // Management command codes
    localparam logic [7:0] CMD_LOOP_GAIN = 8'hDF;
    localparam logic [7:0] CMD_GAIN_RED = 8'hD5;
    localparam logic [7:0] CMD_PHASE = 8'h37;
    // Loop gain word fields
    localparam int GAIN_LSB = 0;
    localparam int RESID_LSB = 16;
    localparam int INTEG_LSB = 24;
    // Gain reduction word fields
    localparam int THR_LSB = 0;
    localparam int THR_W = 12;
    localparam int RED_LSB = 12;
    // Widths
    localparam int ERR_W = 16;
    localparam int PW_W = 8;
    localparam int PH_W = 4;
    localparam int LVL_W = 2;
    localparam int OBS_W = 5;
    // Fixed-point shifts of the three terms
    localparam int P_SHIFT = 12;
    localparam int I_SHIFT = 8;
    localparam int R_SHIFT = 8;
    // Switching cycles of low error before each further gain halving
    localparam logic [OBS_W-1:0] OBS_CYCLES = 5'h10;
    // Values after reset
    localparam logic [31:0] LOOP_GAIN_RST = 32'h1020_0000;
    localparam logic [15:0] GAIN_RED_RST = 16'h1040;
    localparam logic [PH_W-1:0] PHASE_RST = 4'hF;
    localparam logic [PW_W-1:0] PERIOD_RST = 8'h32;
    // Default proportional gain per strap setting
    localparam logic [15:0] STRAP_GAIN_0 = 16'h0400;
    localparam logic [15:0] STRAP_GAIN_1 = 16'h0800;
    localparam logic [15:0] STRAP_GAIN_2 = 16'h1000;
    localparam logic [15:0] STRAP_GAIN_3 = 16'h2000;
endpackage : dlc_pkg

// [design/dlc_phase.sv]
// Switching period measurement and phase-offset cycle start
`timescale 1ns/100ps
module dlc_phase
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronised sync clock level and phase code
    input wire logic sync_lvl,
    input wire logic [PH_W-1:0] phase_code,
    // Cycle timing
    output logic cycle_start_ff,
    output logic [PW_W-1:0] period_ff
);
    logic sync_d_ff, nxt_sync_d;
    logic [PW_W-1:0] per_cnt_ff, nxt_per_cnt;
    logic [PW_W-1:0] nxt_period;
    logic [PW_W-1:0] dly_ff, nxt_dly;
    logic armed_ff, nxt_armed;
    logic nxt_cycle_start;
    logic [PW_W+PH_W:0] prod;
    logic [PW_W-1:0] offset;

    // Period count, offset computation and delayed start
    always_comb begin
        nxt_sync_d = sync_lvl;
        nxt_per_cnt = per_cnt_ff;
        nxt_period = period_ff;
        nxt_dly = dly_ff;
        nxt_armed = armed_ff;
        nxt_cycle_start = 1'b0;
        prod = (PW_W+PH_W+1)'(period_ff) * (PW_W+PH_W+1)'({1'b0, phase_code} + 5'h01);
        offset = prod[PW_W+PH_W-1:PH_W];
        if (offset >= period_ff) begin
            offset = '0;                       // 360 degrees lands on the edge
        end
        if (per_cnt_ff != 8'hFF) begin
            nxt_per_cnt = per_cnt_ff + 8'h01;
        end
        if (armed_ff) begin
            if (dly_ff == '0) begin
                nxt_cycle_start = 1'b1;
                nxt_armed = 1'b0;
            end else begin
                nxt_dly = dly_ff - 8'h01;
            end
        end
        // Rising sync edge re-references the offset
        if (sync_lvl && !sync_d_ff) begin
            if (per_cnt_ff != 8'hFF) begin
                nxt_period = per_cnt_ff + 8'h01;
            end else begin
                nxt_period = 8'hFF;            // Very slow sync saturates
            end
            nxt_per_cnt = '0;
            nxt_dly = offset;
            nxt_armed = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_d_ff <= 1'b0;
            per_cnt_ff <= '0;
            period_ff <= PERIOD_RST;
            dly_ff <= '0;
            armed_ff <= 1'b0;
            cycle_start_ff <= 1'b0;
        end else begin
            sync_d_ff <= nxt_sync_d;
            per_cnt_ff <= nxt_per_cnt;
            period_ff <= nxt_period;
            dly_ff <= nxt_dly;
            armed_ff <= nxt_armed;
            cycle_start_ff <= nxt_cycle_start;
        end
    end
endmodule : dlc_phase

// [design/dlc_pwm.sv]
// Pulse generator: high for the given width from each cycle start
`timescale 1ns/100ps
module dlc_pwm
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Start strobe and width in clock cycles
    input wire logic start,
    input wire logic [PW_W-1:0] width,
    // Pulse out
    output logic pwm_ff
);
    logic [PW_W-1:0] left_ff, nxt_left;
    logic nxt_pwm;

    // Countdown of the remaining high time
    always_comb begin
        nxt_left = left_ff;
        if (start) begin
            nxt_left = width;
        end else if (left_ff != '0) begin
            nxt_left = left_ff - 8'h01;
        end
        nxt_pwm = (nxt_left != '0);
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff <= '0;
            pwm_ff <= 1'b0;
        end else begin
            left_ff <= nxt_left;
            pwm_ff <= nxt_pwm;
        end
    end
endmodule : dlc_pwm

// [bench/dlc_checker_assertions.sv]
// Concurrent checks on the loop compensator ports
`timescale 1ns/100ps
module dlc_checker
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command request
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    // Command answer
    input wire logic cmd_ack_ff,
    input wire logic cmd_err_ff,
    input wire logic [31:0] cmd_rdata_ff,
    // Loop outputs
    input wire logic pwm_out,
    input wire logic [PW_W-1:0] pulse_width_ff,
    input wire logic [LVL_W-1:0] red_level_ff
);
    logic [PW_W-1:0] hi_cnt_ff;
    logic [PW_W-1:0] nxt_hi_cnt;
    logic known;
    // Count clocks the pulse has been high
    always_comb begin
        nxt_hi_cnt = pwm_out ? hi_cnt_ff + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
        end
    end
    // Codes the command port accepts
    assign known = (cmd_code == CMD_LOOP_GAIN) || (cmd_code == CMD_GAIN_RED) ||
        (cmd_code == CMD_PHASE);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Command handshake and refusal
    a_ack_follows: assert property (cmd_valid |=> cmd_ack_ff)
        else $error("ack missing after request");
    a_ack_no_req: assert property (!cmd_valid |=> !cmd_ack_ff)
        else $error("ack without request");
    a_err_unknown: assert property (cmd_valid && !known |=> cmd_err_ff && cmd_rdata_ff == 32'h0)
        else $error("unknown code not refused");
    a_err_known: assert property (cmd_valid && known |=> !cmd_err_ff)
        else $error("known code refused");
    a_rdata_holds: assert property (!cmd_valid |=> $stable(cmd_rdata_ff))
        else $error("read data moved without command");
    // Loop update spacing, reduction steps and pulse length
    a_width_once: assert property ($changed(pulse_width_ff) |=> $stable(pulse_width_ff)[*8])
        else $error("width updated twice in a cycle");
    a_level_step: assert property ($changed(red_level_ff) && red_level_ff != 2'h0 |->
        red_level_ff == $past(red_level_ff) + 2'h1)
        else $error("reduction level jumped");
    a_pulse_length: assert property ($fell(pwm_out) |-> hi_cnt_ff == $past(pulse_width_ff))
        else $error("pulse length differs from width");
    // Main scenarios reached
    c_level_max: cover property (red_level_ff == 2'h3);
    c_unknown: cover property (cmd_valid && !known);
    c_pulse_end: cover property ($fell(pwm_out));
endmodule : dlc_checker
bind dlc_top dlc_checker u_dlc_checker (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ack_ff(cmd_ack_ff), .cmd_err_ff(cmd_err_ff),
    .cmd_rdata_ff(cmd_rdata_ff), .pwm_out(pwm_out), .pulse_width_ff(pulse_width_ff),
    .red_level_ff(red_level_ff));

// [bench/dlc_stage_model.sv]
// Power stage stand-in: makes the sync clock and measures each pulse
`timescale 1ns/100ps
module dlc_stage_model #(
    parameter int PERIOD = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pulse from the compensator
    input wire logic pwm_out,
    // Sync clock and measurements
    output logic sync_ff,
    output logic [7:0] lag_ff,
    output logic [7:0] width_seen_ff
);
    logic [7:0] ph_ff;
    logic [7:0] since_ff;
    logic [7:0] hi_ff;
    logic pwm_d_ff;
    // One common sync clock for all converters, lag and high time of the pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_ff <= 8'h00;
            sync_ff <= 1'b0;
            since_ff <= 8'h00;
            hi_ff <= 8'h00;
            pwm_d_ff <= 1'b0;
            lag_ff <= 8'h00;
            width_seen_ff <= 8'h00;
        end else begin
            ph_ff <= (ph_ff == 8'(PERIOD - 1)) ? 8'h00 : ph_ff + 8'h01;
            sync_ff <= (ph_ff < 8'(PERIOD / 2));
            since_ff <= (ph_ff == 8'h00) ? 8'h00 : since_ff + 8'h01;
            hi_ff <= pwm_out ? hi_ff + 8'h01 : 8'h00;
            pwm_d_ff <= pwm_out;
            if (pwm_out && !pwm_d_ff) begin
                lag_ff <= since_ff;
            end
            if (!pwm_out && pwm_d_ff) begin
                width_seen_ff <= hi_ff;
            end
        end
    end
endmodule : dlc_stage_model

// [bench/dlc_top_bench.sv]
// Self-checking bench of the loop compensator
`timescale 1ns/100ps
module dlc_top_bench;
    import dlc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sync_clk;
    logic [1:0] strap = 2'b10;
    logic signed [ERR_W-1:0] err = 16'sh0000;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [31:0] cmd_wdata = 32'h0;
    logic cmd_ack_ff, cmd_err_ff, pwm_out;
    logic [31:0] cmd_rdata_ff;
    logic [PW_W-1:0] pulse_width_ff, w1;
    logic [LVL_W-1:0] red_level_ff;
    logic [7:0] lag, width_seen;
    int num_errors = 0;
    int n_checks = 0;
    int base = 0;
    logic signed [15:0] st_err [8] = '{16'sd8, 16'sd8, -16'sd8, -16'sd8, 16'sd0, 16'sd0,
        16'sh7FFF, 16'sd0};
    logic [7:0] st_w [8] = '{8'h08, 8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h27, 8'h00};
    always #20 clk = ~clk;
    dlc_top u_dlc_top (.clk(clk), .rst(rst), .sync_clk_pin(sync_clk),
        .config_strap_pin_a(strap), .vout_error(err), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_ack_ff(cmd_ack_ff), .cmd_err_ff(cmd_err_ff), .cmd_rdata_ff(cmd_rdata_ff),
        .pwm_out(pwm_out), .pulse_width_ff(pulse_width_ff), .red_level_ff(red_level_ff));
    dlc_stage_model #(.PERIOD(40)) u_dlc_stage_model (.clk(clk), .rst(rst),
        .pwm_out(pwm_out), .sync_ff(sync_clk), .lag_ff(lag), .width_seen_ff(width_seen));
    // Verdict and end of run
    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    // One comparison
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    // One command with its answer
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [31:0] wd,
        input logic [31:0] exp, input logic exp_err);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_wdata <= wd;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        chk("ack", 32'h1, {31'h0, cmd_ack_ff});
        chk("err", {31'h0, exp_err}, {31'h0, cmd_err_ff});
        chk("rdata", exp, cmd_rdata_ff);
    endtask : cmd
    // Wait until this switching cycle's update has settled
    task automatic next_cyc();
        @(posedge sync_clk);
        repeat (20) @(posedge clk);
    endtask : next_cyc
    // Hang guard
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    // Test sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        cmd(0, CMD_LOOP_GAIN, 0, {LOOP_GAIN_RST[31:16], STRAP_GAIN_2}, 0);
        cmd(0, CMD_GAIN_RED, 0, {16'h0, GAIN_RED_RST}, 0);
        cmd(0, CMD_PHASE, 0, {28'h0, PHASE_RST}, 0);
        cmd(1, CMD_GAIN_RED, 32'h0000_0004, 0, 0);
        cmd(1, CMD_LOOP_GAIN, 32'h0080_1000, 0, 0);
        cmd(1, 8'hAA, 32'hFFFF_FFFF, 0, 1);
        cmd(0, CMD_LOOP_GAIN, 0, 32'h0080_1000, 0);
        // Error steps: proportional now, residual one cycle later, saturation
        for (int i = 0; i < 8; i++) begin
            err <= st_err[i];
            next_cyc();
            chk("width", {24'h0, st_w[i]}, {24'h0, pulse_width_ff});
            if (st_w[i] != 8'h00 && st_w[i] < 8'h10) begin
                chk("pulse", {24'h0, st_w[i]}, {24'h0, width_seen});
            end
        end
        // Every phase offset code
        err <= 16'sd8;
        cmd(1, CMD_LOOP_GAIN, 32'h0000_1000, 0, 0);
        for (int c = 15; c >= 0; c--) begin
            cmd(1, CMD_PHASE, 32'(c), 0, 0);
            cmd(0, CMD_PHASE, 0, 32'(c), 0);
            repeat (3) next_cyc();
            if (c == 15) begin
                base = int'(lag);
            end
            chk("offset", (c == 15) ? 0 : 40 * (c + 1) / 16, (int'(lag) - base + 40) % 40);
        end
        // Gain reduction per setting, error equal to threshold counts as low
        for (int c = 0; c < 4; c++) begin
            cmd(1, CMD_GAIN_RED, 32'(c << 12) | 32'h4, 0, 0);
            err <= 16'sd4;
            repeat (60) next_cyc();
            chk("level", 32'(c), {30'h0, red_level_ff});
            chk("width", 32'(4 >> c), {24'h0, pulse_width_ff});
            err <= 16'sd5;
            next_cyc();
            chk("level", 0, {30'h0, red_level_ff});
            chk("width", 5, {24'h0, pulse_width_ff});
        end
        // Integral term alone climbs one step per cycle
        cmd(1, CMD_LOOP_GAIN, 32'h4000_0000, 0, 0);
        repeat (2) next_cyc();
        w1 = pulse_width_ff;
        next_cyc();
        chk("integ", {24'h0, w1 + 8'h01}, {24'h0, pulse_width_ff});
        end_of_test();
    end
endmodule : dlc_top_bench
